// ===== hdl/css_regs.sv
// Cache size selection and upper system control register logic.
`timescale 1ns/1ns
// Contract
// - Selection register access only from privileged software.
// - Selection level bits 3 to 1 read zero, writes ignored.
// - Selection bit 0: one picks instruction cache, zero data cache.
// - Selection reached by opcode1 2, c0, c0, opcode2 0, read and write.
// - Size identification returns geometry of the selected cache.
// - System control register access only from privileged software.
// - Bit 30 picks the instruction state used on exception entry.
// - Bit 30 reset value comes from the state init pin.
// - Bit 27 read-only, reset value from its configuration pin.
// - Every exception copies bit 25 into the status endianness bit.
// - Bit 25 reset value comes from the endianness pin.
module css_regs
	import css_pkg::*;
#(
	parameter logic [31:0] ICACHE_GEOM = 32'h2000_0000,
	parameter logic [31:0] DCACHE_GEOM = 32'h7000_0000
)
(
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	input  wire css_cp_req_s req_i,
	output css_cp_rsp_s      rsp_o,
	input  wire logic        exception_state_init_pin_i,
	input  wire logic        nonmaskable_fast_irq_cfg_pin_i,
	input  wire logic        endianness_cfg_pin_i,
	input  wire logic        exception_i,
	output logic             exception_instr_state_o,
	output logic             nonmaskable_fast_irq_flag_o,
	output logic             exception_endianness_o,
	output logic             cps_endian_o,
	output logic             cps_endian_load_o
);

	logic        pin_te_m;
	logic        pin_te_s;
	logic        pin_nm_m;
	logic        pin_nm_s;
	logic        pin_ee_m;
	logic        pin_ee_s;
	logic        straps_done;
	logic        instr_or_data_select_q;
	logic        te_q;
	logic        nm_q;
	logic        ee_q;
	logic        hit_sel;
	logic        hit_ident;
	logic        hit_ctl;
	logic        hit_any;
	logic        ok;
	logic [31:0] rdata_d;

	function automatic logic decode(input css_cp_req_s r,
		input logic [2:0] o1, input logic [3:0] n, input logic [3:0] m,
		input logic [2:0] o2);
		decode = r.opc1 == o1 && r.crn == n && r.crm == m && r.opc2 == o2;
	endfunction

	// Strap pins are synchronised before any logic reads them.
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pin_te_m <= 1'b0;
			pin_te_s <= 1'b0;
			pin_nm_m <= 1'b0;
			pin_nm_s <= 1'b0;
			pin_ee_m <= 1'b0;
			pin_ee_s <= 1'b0;
		end
		else
		begin
			pin_te_m <= exception_state_init_pin_i;
			pin_te_s <= pin_te_m;
			pin_nm_m <= nonmaskable_fast_irq_cfg_pin_i;
			pin_nm_s <= pin_nm_m;
			pin_ee_m <= endianness_cfg_pin_i;
			pin_ee_s <= pin_ee_m;
		end
	end

	// Straps are caught at the third edge after reset release.
	logic [1:0] strap_cnt_q;
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			strap_cnt_q <= 2'h0;
		else if (strap_cnt_q != CSS_STRAP_LAST)
			strap_cnt_q <= strap_cnt_q + 2'h1;
	end
	assign straps_done = strap_cnt_q == CSS_STRAP_LAST;

	assign hit_sel   = decode(req_i, CSS_OPC1_SEL, CSS_CRN_C0, CSS_CRM_C0,
		CSS_OPC2_ZERO);
	assign hit_ident = decode(req_i, CSS_OPC1_IDENT, CSS_CRN_C0,
		CSS_CRM_C0, CSS_OPC2_ZERO);
	assign hit_ctl   = decode(req_i, CSS_OPC1_CTL, CSS_CRN_C1, CSS_CRM_C0,
		CSS_OPC2_ZERO);
	assign hit_any = hit_sel || hit_ident || hit_ctl;
	assign ok = req_i.valid && req_i.priv && hit_any && straps_done;

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			instr_or_data_select_q <= 1'b0;
		else if (ok && req_i.write && hit_sel)
			instr_or_data_select_q <= req_i.wdata[CSS_SEL_IND_BIT];
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			te_q <= 1'b0;
			nm_q <= 1'b0;
			ee_q <= 1'b0;
		end
		else if (!straps_done)
		begin
			te_q <= pin_te_s;
			nm_q <= pin_nm_s;
			ee_q <= pin_ee_s;
		end
		else if (ok && req_i.write && hit_ctl)
		begin
			te_q <= req_i.wdata[CSS_CTL_TE_BIT];
			ee_q <= req_i.wdata[CSS_CTL_EE_BIT];
		end
	end

	always_comb
	begin
		rdata_d = CSS_ZERO;
		if (hit_sel)
			rdata_d[CSS_SEL_IND_BIT] = instr_or_data_select_q;
		else if (hit_ident)
			rdata_d = instr_or_data_select_q ? ICACHE_GEOM : DCACHE_GEOM;
		else if (hit_ctl)
		begin
			rdata_d[CSS_CTL_TE_BIT] = te_q;
			rdata_d[CSS_CTL_NM_BIT] = nm_q;
			rdata_d[CSS_CTL_EE_BIT] = ee_q;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rsp_o <= '0;
		end
		else
		begin
			rsp_o.ack   <= req_i.valid;
			rsp_o.undef <= req_i.valid && !ok;
			rsp_o.rdata <= (ok && !req_i.write) ? rdata_d : CSS_ZERO;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cps_endian_o      <= 1'b0;
			cps_endian_load_o <= 1'b0;
		end
		else
		begin
			cps_endian_load_o <= exception_i;
			if (exception_i)
				cps_endian_o <= ee_q;
		end
	end

	assign exception_instr_state_o     = te_q;
	assign nonmaskable_fast_irq_flag_o = nm_q;
	assign exception_endianness_o      = ee_q;

	// Single-cycle access steps that the properties below are built from.
	sequence s_sel_write;
		ok && req_i.write && hit_sel;
	endsequence

	sequence s_sel_read;
		ok && !req_i.write && hit_sel;
	endsequence

	sequence s_ident_read;
		ok && !req_i.write && hit_ident;
	endsequence

	sequence s_ident_write;
		ok && req_i.write && hit_ident;
	endsequence

	sequence s_ctl_write;
		ok && req_i.write && hit_ctl;
	endsequence

	sequence s_ctl_read;
		ok && !req_i.write && hit_ctl;
	endsequence

	sequence s_unpriv;
		req_i.valid && !req_i.priv;
	endsequence

	sequence s_refused;
		req_i.valid && !ok;
	endsequence

	sequence s_refused_answer;
		rsp_o.ack && rsp_o.undef && rsp_o.rdata == CSS_ZERO;
	endsequence

	a_sel_write: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i) s_sel_write |=>
		instr_or_data_select_q == $past(req_i.wdata[CSS_SEL_IND_BIT]))
		else $error("selection write lost");
	a_sel_read: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i) s_sel_read |=>
		rsp_o.rdata[CSS_SEL_IND_BIT] == $past(instr_or_data_select_q))
		else $error("selection read wrong");
	a_level_zero: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i) s_sel_read |=> rsp_o.rdata[3:1] == 3'h0)
		else $error("level field not zero");
	a_sel_upper: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i) s_sel_read |=> rsp_o.rdata[31:4] == 28'h0)
		else $error("selection upper bits not zero");
	a_sel_unpriv: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i) s_unpriv ##0 hit_sel |=>
		$stable(instr_or_data_select_q))
		else $error("unprivileged selection write took effect");
	a_unpriv_block: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i) s_unpriv |=> s_refused_answer)
		else $error("unprivileged access not refused");
	a_refused_answer: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i) s_refused |=> s_refused_answer)
		else $error("refused access not answered as refused");
	a_ctl_unpriv: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i)
		s_unpriv ##0 (hit_ctl && straps_done) |=>
		$stable(te_q) && $stable(ee_q))
		else $error("unprivileged control write took effect");
	a_ident_geom: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i) s_ident_read |=> rsp_o.rdata ==
		($past(instr_or_data_select_q) ? ICACHE_GEOM : DCACHE_GEOM))
		else $error("wrong cache geometry");
	a_ident_ro: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i) s_ident_write |=>
		$stable(instr_or_data_select_q))
		else $error("size identification write took effect");
	a_te_write: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i) s_ctl_write |=>
		exception_instr_state_o == $past(req_i.wdata[CSS_CTL_TE_BIT]))
		else $error("state bit write lost");
	a_ee_write: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i) s_ctl_write |=>
		exception_endianness_o == $past(req_i.wdata[CSS_CTL_EE_BIT]))
		else $error("endianness bit write lost");
	a_ctl_read: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i) s_ctl_read |=>
		rsp_o.rdata[CSS_CTL_TE_BIT] == $past(te_q) &&
		rsp_o.rdata[CSS_CTL_NM_BIT] == $past(nm_q) &&
		rsp_o.rdata[CSS_CTL_EE_BIT] == $past(ee_q))
		else $error("control read wrong");
	a_ctl_reserved: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i) s_ctl_read |=>
		rsp_o.rdata[31] == 1'b0 && rsp_o.rdata[29:28] == 2'h0 &&
		rsp_o.rdata[26] == 1'b0 && rsp_o.rdata[24:0] == 25'h0)
		else $error("reserved bits not zero");
	a_nm_readonly: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i) straps_done |=> $stable(nm_q))
		else $error("nonmaskable flag changed");
	a_strap_load: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i) !straps_done |=>
		te_q == $past(pin_te_s) && ee_q == $past(pin_ee_s))
		else $error("strap not loaded");
	a_nm_strap: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i) !straps_done |=> nm_q == $past(pin_nm_s))
		else $error("nonmaskable strap not loaded");
	a_strap_refuse: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i)
		req_i.valid && !straps_done |=> rsp_o.undef)
		else $error("access during strap capture not refused");
	a_ack_pulse: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i) req_i.valid |=> rsp_o.ack)
		else $error("access not acknowledged");
	a_ack_idle: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i)
		!req_i.valid |=> !rsp_o.ack && !rsp_o.undef)
		else $error("answer without access");
	a_write_quiet: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i) req_i.valid && req_i.write |=>
		rsp_o.rdata == CSS_ZERO)
		else $error("write returned data");
	a_exc_endian: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i) exception_i |=>
		cps_endian_load_o && cps_endian_o == $past(ee_q))
		else $error("exception endianness wrong");
	a_exc_idle: assert property (@(posedge mclk_i)
		disable iff (!rst_n_i) !exception_i |=>
		!cps_endian_load_o && $stable(cps_endian_o))
		else $error("status endianness moved without exception");

endmodule

// ===== shared/css_pkg.sv
// Package with constants and types for the cache select and control block.
package css_pkg;

	localparam logic [2:0] CSS_OPC1_SEL   = 3'h2;
	localparam logic [2:0] CSS_OPC1_IDENT = 3'h1;
	localparam logic [3:0] CSS_CRN_C0     = 4'h0;
	localparam logic [3:0] CSS_CRM_C0     = 4'h0;
	localparam logic [2:0] CSS_OPC2_ZERO  = 3'h0;
	localparam logic [2:0] CSS_OPC1_CTL   = 3'h0;
	localparam logic [3:0] CSS_CRN_C1     = 4'h1;

	localparam int CSS_SEL_IND_BIT = 0;
	localparam int CSS_CTL_TE_BIT  = 30;
	localparam int CSS_CTL_NM_BIT  = 27;
	localparam int CSS_CTL_EE_BIT  = 25;

	localparam logic [31:0] CSS_ZERO = 32'h0000_0000;

	localparam logic [1:0] CSS_STRAP_LAST = 2'h3;

	// One coprocessor access as presented by the pipeline.
	typedef struct packed {
		logic       valid;
		logic       write;
		logic       priv;
		logic [2:0] opc1;
		logic [3:0] crn;
		logic [3:0] crm;
		logic [2:0] opc2;
		logic [31:0] wdata;
	} css_cp_req_s;

	// Answer to one coprocessor access.
	typedef struct packed {
		logic        ack;
		logic        undef;
		logic [31:0] rdata;
	} css_cp_rsp_s;

endpackage

// ===== verif/test_css_regs.sv
// Testbench for the cache select and upper control register logic.
`timescale 1ns/1ns
module test_css_regs
	import css_pkg::*;
;
	localparam logic Y = 1'h1;
	localparam logic N = 1'h0;
	localparam logic [31:0] F = 32'hFFFF_FFFF;
	localparam logic [31:0] Z = 32'h0;
	logic        mclk_i = 1'h0;
	logic        rst_n_i = 1'h0;
	css_cp_req_s req;
	css_cp_rsp_s rsp;
	logic        te_pin, nm_pin, ee_pin, exc;
	logic        te_o, nm_o, ee_o, cps_e, cps_ld;
	int          errors = 0;
	int          checks_done = 0;
	int          cycles = 0;

	always #5 mclk_i = ~mclk_i;

	css_regs u_css_regs (
		.mclk_i                         (mclk_i),
		.rst_n_i                        (rst_n_i),
		.req_i                          (req),
		.rsp_o                          (rsp),
		.exception_state_init_pin_i     (te_pin),
		.nonmaskable_fast_irq_cfg_pin_i (nm_pin),
		.endianness_cfg_pin_i           (ee_pin),
		.exception_i                    (exc),
		.exception_instr_state_o        (te_o),
		.nonmaskable_fast_irq_flag_o    (nm_o),
		.exception_endianness_o         (ee_o),
		.cps_endian_o                   (cps_e),
		.cps_endian_load_o              (cps_ld)
	);

	task stop_test();
		$display("errors=%0d checks_done=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge mclk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			errors++;
			stop_test();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task rst(input logic t, input logic n, input logic e);
		@(negedge mclk_i);
		rst_n_i = 1'h0;
		{te_pin, nm_pin, ee_pin} = {t, n, e};
		repeat (3) @(negedge mclk_i);
		rst_n_i = 1'h1;
	endtask

	task acc(input logic p, input logic w, input logic [2:0] o1,
		input logic [3:0] n, input logic [31:0] wd, input logic eu,
		input logic [31:0] ed);
		@(negedge mclk_i);
		req = '{Y, w, p, o1, n, 4'h0, 3'h0, wd};
		@(posedge mclk_i);
		@(negedge mclk_i);
		req.valid = 1'h0;
		chk({30'h0, rsp.ack, rsp.undef}, {30'h0, Y, eu});
		chk(rsp.rdata, ed);
	endtask

	task exc_chk(input logic e);
		@(negedge mclk_i);
		exc = 1'h1;
		@(posedge mclk_i);
		@(negedge mclk_i);
		exc = 1'h0;
		chk({30'h0, cps_ld, cps_e}, {30'h0, Y, e});
	endtask

	initial
	begin
		req = '0;
		exc = 1'h0;
		{te_pin, nm_pin, ee_pin} = 3'h6;
		rst(Y, Y, N);
		acc(Y, N, 3'h0, 4'h1, Z, Y, Z);
		acc(Y, N, 3'h0, 4'h1, Z, N, 32'h4800_0000);
		chk({29'h0, te_o, nm_o, ee_o}, 32'h6);
		acc(Y, Y, 3'h0, 4'h1, F, N, Z);
		acc(Y, N, 3'h0, 4'h1, Z, N, 32'h4A00_0000);
		exc_chk(Y);
		acc(N, Y, 3'h0, 4'h1, Z, Y, Z);
		acc(N, N, 3'h0, 4'h1, Z, Y, Z);
		acc(Y, N, 3'h0, 4'h1, Z, N, 32'h4A00_0000);
		acc(Y, Y, 3'h0, 4'h1, Z, N, Z);
		acc(Y, N, 3'h0, 4'h1, Z, N, 32'h0800_0000);
		chk({29'h0, te_o, nm_o, ee_o}, 32'h2);
		exc_chk(N);
		acc(Y, Y, 3'h2, 4'h0, F, N, Z);
		acc(Y, N, 3'h2, 4'h0, Z, N, 32'h1);
		acc(Y, N, 3'h1, 4'h0, Z, N, 32'h2000_0000);
		acc(N, Y, 3'h2, 4'h0, Z, Y, Z);
		acc(N, N, 3'h2, 4'h0, Z, Y, Z);
		acc(Y, N, 3'h2, 4'h0, Z, N, 32'h1);
		acc(Y, Y, 3'h2, 4'h0, 32'hFFFF_FFFE, N, Z);
		acc(Y, N, 3'h2, 4'h0, Z, N, Z);
		acc(Y, N, 3'h1, 4'h0, Z, N, 32'h7000_0000);
		acc(Y, Y, 3'h1, 4'h0, F, N, Z);
		acc(Y, N, 3'h1, 4'h0, Z, N, 32'h7000_0000);
		acc(Y, N, 3'h7, 4'h5, Z, Y, Z);
		rst(N, N, Y);
		acc(Y, N, 3'h0, 4'h1, Z, Y, Z);
		acc(Y, N, 3'h0, 4'h1, Z, N, 32'h0200_0000);
		chk({29'h0, te_o, nm_o, ee_o}, 32'h1);
		acc(Y, Y, 3'h0, 4'h1, F, N, Z);
		acc(Y, N, 3'h0, 4'h1, Z, N, 32'h4200_0000);
		chk({29'h0, te_o, nm_o, ee_o}, 32'h5);
		exc_chk(Y);
		stop_test();
	end
endmodule
